//--- core/acs_map.vh
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// How it works
// - Serial input bits are taken on the rising serial clock edge.
// - Once a frame is clocked, ready/data-out pin changes only on falling serial clock edges.
// - Outside data shifting, pin low means a result waits to be read.
// - Chip select is active low; serial activity is ignored while high.
// - Off-nominal external clock scales data rate and notches proportionally.
// - Mains select zero picks the higher oscillator, one the lower.
// - Input sampling rate is the system clock divided by ten.
// - The oscillator, or the external clock when control register one selects it, gives the system clock; all timing divides from it.
// - Buffer enable bit of control register one switches the input buffer.
// - Polarity bit picks unipolar or bipolar transfer function.
// - Continuous codes 100 to 111 give 60 to 480 or 50 to 400 sps.
// - Single-cycle codes 000 to 111 give 1 to 120 or 0.833 to 100 sps.
// - Four auxiliary pins have direction and level set over the serial port.
// - Single-shot bit zero is continuous, one is single conversion.
// - Continuous mode discards three conversions to settle after a change.
// - Chip select high releases the pin; chip select low drives it again.

// Master clock and oscillators, in Hz
`define ACS_MCLK_HZ 64'd125000000
`define ACS_OSC_HI_HZ 64'd2457600
`define ACS_OSC_LO_HZ 64'd2048000
`define ACS_NCO_W 24
`define ACS_SMP_DIV 4'h9

// Serial frame
`define ACS_CMD_BITS 6'h08
`define ACS_WR_BITS 6'h10
`define ACS_CMD_RD 7
`define ACS_WORD_W 24

// Register addresses
`define ACS_ADR_DATA 3'h0
`define ACS_ADR_CR1 3'h1
`define ACS_ADR_AUX 3'h2
`define ACS_ADR_RATE 3'h3

// Control register one fields
`define ACS_CR1_SSHOT 0
`define ACS_CR1_UNIP 1
`define ACS_CR1_BUF 2
`define ACS_CR1_MAINS 3
`define ACS_CR1_EXT 4
`define ACS_CR1_RST 8'h00
`define ACS_AUX_RST 8'h00
`define ACS_RATE_RST 8'h00
`define ACS_RATE_STOP 7

// Modulator samples per single-cycle conversion, by rate code
`define ACS_SMP_R0 18'h3C000
`define ACS_SMP_R1 18'h18000
`define ACS_SMP_R2 18'h0C000
`define ACS_SMP_R3 18'h06000
`define ACS_SMP_R4 18'h04000
`define ACS_SMP_R5 18'h02000
`define ACS_SMP_R6 18'h01000
`define ACS_SMP_R7 18'h00800
`define ACS_CONT_SHIFT 2
`define ACS_SETTLE 2'h3
`endif

//--- core/acs_clkgen.v
`include "acs_map.vh"
module acs_clkgen #(
	parameter NCO_W = `ACS_NCO_W
) (
	// Clock and reset
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	// Source selection
	input wire ext_sel_i,
	input wire mains_sel_i,
	input wire ext_clk_i,
	// Ticks
	output reg sys_tick_o,
	output reg sample_tick_o
);
	localparam [63:0] INC_HI = (`ACS_OSC_HI_HZ << NCO_W) / `ACS_MCLK_HZ;
	localparam [63:0] INC_LO = (`ACS_OSC_LO_HZ << NCO_W) / `ACS_MCLK_HZ;
	reg [NCO_W-1:0] acc_reg;
	reg ext_prev_reg;
	reg [3:0] div_reg;
	wire [NCO_W-1:0] inc;
	wire [NCO_W:0] sum;
	// Phase accumulator stands in for the trimmed oscillator; jitter is one mclk
	assign inc = mains_sel_i ? INC_LO[NCO_W-1:0] : INC_HI[NCO_W-1:0];
	assign sum = {1'b0, acc_reg} + {1'b0, inc};
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			acc_reg <= {NCO_W{1'b0}};
			ext_prev_reg <= 1'b0;
			div_reg <= 4'h0;
			sys_tick_o <= 1'b0;
			sample_tick_o <= 1'b0;
		end else if (ce_i) begin
			acc_reg <= sum[NCO_W-1:0];
			ext_prev_reg <= ext_clk_i;
			// External edges replace the oscillator, so rates follow its frequency
			sys_tick_o <= ext_sel_i ? (ext_clk_i & ~ext_prev_reg) : sum[NCO_W];
			sample_tick_o <= 1'b0;
			if (sys_tick_o) begin
				if (div_reg == `ACS_SMP_DIV) begin
					div_reg <= 4'h0;
					sample_tick_o <= 1'b1;
				end else begin
					div_reg <= div_reg + 4'h1;
				end
			end
		end
	end
endmodule

//--- core/acs_fifo.v
module acs_fifo #(
	parameter W = 24,
	parameter D = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	// Fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// Drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	wire push;
	wire pop;
	genvar i;
	assign in_ready_o = (cnt_reg != D[AW:0]);
	assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
	assign out_data_o = mem[rd_reg];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	generate
		for (i = 0; i < D; i = i + 1) begin : g_ent
			localparam [AW-1:0] IDX = i;
			always @(posedge mclk_i) begin
				if (ce_i && push && wr_reg == IDX) begin
					mem[i] <= in_data_i;
				end
			end
		end
	endgenerate
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else if (ce_i) begin
			if (push) begin
				wr_reg <= (wr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

//--- core/acs_ctrl.v
`include "acs_map.vh"
module acs_ctrl #(
	parameter CONV_DIV_SHIFT = 0,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	// Clock, reset, enable
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	// Serial port
	input wire sclk_i,
	input wire cs_b_i,
	input wire din_i,
	output reg rdy_dout_o,
	output reg rdy_dout_oe_o,
	// External clock
	input wire ext_clk_i,
	// Auxiliary pins
	input wire [3:0] aux_io_i,
	output reg [3:0] aux_io_o,
	output reg [3:0] aux_io_oe_o,
	// Converter core
	input wire [23:0] filter_data_i,
	output wire sample_tick_o,
	output reg conv_start_o,
	output reg input_buffer_enable_o,
	output reg unipolar_o,
	output reg mains_freq_select_o,
	output reg ext_clock_select_o,
	output reg single_shot_mode_o,
	output reg [2:0] active_rate_o,
	output reg busy_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;
	localparam W = `ACS_WORD_W;

	// Serial state
	reg sclk_prev_reg;
	reg [5:0] bit_cnt_reg;
	reg [7:0] sh_in_reg;
	reg [7:0] cmd_reg;
	reg [W-1:0] out_sh_reg;
	reg shifting_reg;
	reg [4:0] out_cnt_reg;
	reg pop_reg;

	// Written registers
	reg [7:0] control_reg_one;
	reg [7:0] aux_reg;
	reg [7:0] rate_reg;
	reg start_reg;
	reg stop_reg;

	// Conversion state
	reg state_reg;
	reg run_reg;
	reg [17:0] conv_cnt_reg;
	reg [17:0] target_reg;
	reg [1:0] drop_reg;
	reg push_reg;
	reg [W-1:0] push_data_reg;

	// Combinational
	reg [17:0] smp_next;
	reg [W-1:0] rd_word;
	reg [W-1:0] result;
	wire rise;
	wire fall;
	wire [7:0] byte_in;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [W-1:0] fifo_out_data;
	wire rdy_level;

	assign rise = sclk_i & ~sclk_prev_reg;
	assign fall = ~sclk_i & sclk_prev_reg;
	assign byte_in = {sh_in_reg[6:0], din_i};
	assign rdy_level = ~fifo_out_valid;

	acs_clkgen #(
		.NCO_W(`ACS_NCO_W)
	) u_clk (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.ext_sel_i(ext_clock_select_o),
		.mains_sel_i(mains_freq_select_o),
		.ext_clk_i(ext_clk_i),
		.sys_tick_o(),
		.sample_tick_o(sample_tick_o)
	);

	acs_fifo #(
		.W(W),
		.D(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.in_valid_i(push_reg),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data_reg),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop_reg),
		.out_data_o(fifo_out_data)
	);

	// Samples per conversion from the pending configuration
	always @* begin
		case (rate_reg[2:0])
			3'h0: smp_next = `ACS_SMP_R0;
			3'h1: smp_next = `ACS_SMP_R1;
			3'h2: smp_next = `ACS_SMP_R2;
			3'h3: smp_next = `ACS_SMP_R3;
			3'h4: smp_next = `ACS_SMP_R4;
			3'h5: smp_next = `ACS_SMP_R5;
			3'h6: smp_next = `ACS_SMP_R6;
			3'h7: smp_next = `ACS_SMP_R7;
			default: smp_next = `ACS_SMP_R0;
		endcase
		// Continuous runs four times faster; codes below 100 fall back to 100
		if (!control_reg_one[`ACS_CR1_SSHOT]) begin
			if (!rate_reg[2]) begin
				smp_next = `ACS_SMP_R4;
			end
			smp_next = smp_next >> `ACS_CONT_SHIFT;
		end
		smp_next = smp_next >> CONV_DIV_SHIFT;
		if (smp_next == 18'h00000) begin
			smp_next = 18'h00001;
		end
	end

	// Word returned by a read frame
	always @* begin
		case (byte_in[6:4])
			`ACS_ADR_DATA: rd_word = fifo_out_valid ? fifo_out_data : {W{1'b0}};
			`ACS_ADR_CR1: rd_word = {control_reg_one, 16'h0000};
			`ACS_ADR_AUX: rd_word = {aux_reg[7:4], aux_io_i, 16'h0000};
			`ACS_ADR_RATE: rd_word = {run_reg, state_reg, fifo_out_valid, 2'h0,
				rate_reg[2:0], 16'h0000};
			default: rd_word = {W{1'b0}};
		endcase
	end

	// Unipolar range clamps below-zero codes to zero
	always @* begin
		result = filter_data_i;
		if (unipolar_o && filter_data_i[W-1]) begin
			result = {W{1'b0}};
		end
	end

	// Serial port
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			sclk_prev_reg <= 1'b0;
			bit_cnt_reg <= 6'h00;
			sh_in_reg <= 8'h00;
			cmd_reg <= 8'h00;
			out_sh_reg <= {W{1'b0}};
			shifting_reg <= 1'b0;
			out_cnt_reg <= 5'h00;
			pop_reg <= 1'b0;
			rdy_dout_o <= 1'b1;
			rdy_dout_oe_o <= 1'b0;
			control_reg_one <= `ACS_CR1_RST;
			aux_reg <= `ACS_AUX_RST;
			rate_reg <= `ACS_RATE_RST;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			aux_io_o <= 4'h0;
			aux_io_oe_o <= 4'h0;
		end else if (ce_i) begin
			sclk_prev_reg <= sclk_i;
			pop_reg <= 1'b0;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			rdy_dout_oe_o <= ~cs_b_i;
			aux_io_o <= aux_reg[3:0];
			aux_io_oe_o <= aux_reg[7:4];
			if (cs_b_i) begin
				// Frame aborted or ended: drop any partial command
				bit_cnt_reg <= 6'h00;
				shifting_reg <= 1'b0;
				out_cnt_reg <= 5'h00;
				rdy_dout_o <= rdy_level;
			end else begin
				// Before the first clock edge the pin follows ready live
				if (bit_cnt_reg == 6'h00 && !shifting_reg) begin
					rdy_dout_o <= rdy_level;
				end
				if (rise) begin
					sh_in_reg <= byte_in;
					if (bit_cnt_reg != 6'h3F) begin
						bit_cnt_reg <= bit_cnt_reg + 6'h01;
					end
					if (bit_cnt_reg == `ACS_CMD_BITS - 6'h01) begin
						cmd_reg <= byte_in;
						if (byte_in[`ACS_CMD_RD]) begin
							out_sh_reg <= rd_word;
							shifting_reg <= 1'b1;
							out_cnt_reg <= 5'h00;
							if (byte_in[6:4] == `ACS_ADR_DATA) begin
								pop_reg <= fifo_out_valid;
							end
						end
					end
					if (bit_cnt_reg == `ACS_WR_BITS - 6'h01 && !cmd_reg[`ACS_CMD_RD]) begin
						case (cmd_reg[6:4])
							`ACS_ADR_CR1: control_reg_one <= byte_in;
							`ACS_ADR_AUX: aux_reg <= byte_in;
							`ACS_ADR_RATE: begin
								rate_reg <= byte_in;
								start_reg <= ~byte_in[`ACS_RATE_STOP];
								stop_reg <= byte_in[`ACS_RATE_STOP];
							end
							default: begin
							end
						endcase
					end
				end
				if (fall && bit_cnt_reg != 6'h00) begin
					// Host samples on the next rising edge
					if (shifting_reg) begin
						rdy_dout_o <= out_sh_reg[W-1];
						out_sh_reg <= {out_sh_reg[W-2:0], 1'b0};
						out_cnt_reg <= out_cnt_reg + 5'h01;
						if (out_cnt_reg == W[4:0] - 5'h01) begin
							shifting_reg <= 1'b0;
						end
					end else begin
						rdy_dout_o <= rdy_level;
					end
				end
			end
		end
	end

	// Conversion sequencer
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
			run_reg <= 1'b0;
			conv_cnt_reg <= 18'h00000;
			target_reg <= 18'h00001;
			drop_reg <= 2'h0;
			push_reg <= 1'b0;
			push_data_reg <= {W{1'b0}};
			conv_start_o <= 1'b0;
			busy_o <= 1'b0;
			input_buffer_enable_o <= 1'b0;
			unipolar_o <= 1'b0;
			mains_freq_select_o <= 1'b0;
			ext_clock_select_o <= 1'b0;
			single_shot_mode_o <= 1'b0;
			active_rate_o <= 3'h0;
		end else if (ce_i) begin
			push_reg <= 1'b0;
			conv_start_o <= 1'b0;
			if (start_reg) begin
				run_reg <= 1'b1;
				if (!control_reg_one[`ACS_CR1_SSHOT]) begin
					drop_reg <= `ACS_SETTLE;
				end
			end else if (stop_reg) begin
				run_reg <= 1'b0;
			end
			case (state_reg)
				ST_IDLE: begin
					// Full FIFO holds off the next conversion
					if (run_reg && fifo_in_ready && !stop_reg) begin
						input_buffer_enable_o <= control_reg_one[`ACS_CR1_BUF];
						unipolar_o <= control_reg_one[`ACS_CR1_UNIP];
						mains_freq_select_o <= control_reg_one[`ACS_CR1_MAINS];
						ext_clock_select_o <= control_reg_one[`ACS_CR1_EXT];
						single_shot_mode_o <= control_reg_one[`ACS_CR1_SSHOT];
						active_rate_o <= rate_reg[2:0];
						target_reg <= smp_next;
						conv_cnt_reg <= 18'h00000;
						conv_start_o <= 1'b1;
						busy_o <= 1'b1;
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (sample_tick_o) begin
						if (conv_cnt_reg == target_reg - 18'h00001) begin
							busy_o <= 1'b0;
							state_reg <= ST_IDLE;
							if (drop_reg != 2'h0 && !single_shot_mode_o) begin
								drop_reg <= drop_reg - 2'h1;
							end else begin
								push_reg <= 1'b1;
								push_data_reg <= result;
							end
							if (single_shot_mode_o && !start_reg) begin
								run_reg <= 1'b0;
							end
						end else begin
							conv_cnt_reg <= conv_cnt_reg + 18'h00001;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

//--- tb/acs_ctrl_assertions.sv
module acs_ctrl_assertions (
	// Clock and reset
	input logic mclk_i,
	input logic rst_b_i,
	// Serial pins
	input logic sclk_i,
	input logic cs_b_i,
	input logic rdy_dout_o,
	input logic rdy_dout_oe_o,
	// Auxiliary pins
	input logic [3:0] aux_io_o,
	input logic [3:0] aux_io_oe_o,
	// Converter side
	input logic sample_tick_o,
	input logic conv_start_o,
	input logic mains_freq_select_o,
	input logic ext_clock_select_o,
	input logic single_shot_mode_o,
	input logic [2:0] active_rate_o,
	input logic busy_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	// A source change spoils the gap around it, so that gap is skipped
	logic [10:0] gap_reg;
	logic ok_reg;
	always @(posedge mclk_i) begin
		gap_reg <= sample_tick_o ? 11'h001 : gap_reg + 11'h001;
		ok_reg <= rst_b_i && !ext_clock_select_o && (ok_reg || sample_tick_o)
			&& $stable(mains_freq_select_o);
	end
	chk_oe_follows_cs: assert property ($past(rst_b_i) |-> rdy_dout_oe_o == !$past(cs_b_i))
		else $error("pin enable does not follow chip select");
	chk_dout_still_high: assert property ($past(sclk_i, 2) && $past(sclk_i) && sclk_i && !cs_b_i |-> $stable(rdy_dout_o))
		else $error("data out moved while serial clock high");
	chk_start_busy: assert property (conv_start_o |-> ##[0:1] busy_o)
		else $error("conversion start without busy");
	chk_cfg_at_start: assert property (!conv_start_o && !$past(conv_start_o) |-> $stable({mains_freq_select_o, single_shot_mode_o, active_rate_o}))
		else $error("configuration changed outside a conversion start");
	chk_tick_pulse: assert property (sample_tick_o |=> !sample_tick_o [*8])
		else $error("sample tick too long or too dense");
	chk_tick_rate: assert property (sample_tick_o && ok_reg |-> (mains_freq_select_o ? gap_reg >= 11'h260 && gap_reg <= 11'h265 : gap_reg >= 11'h1FA && gap_reg <= 11'h1FF))
		else $error("sample tick spacing wrong");
	chk_quiet_unselected: assert property (cs_b_i && $past(cs_b_i) |-> $stable(aux_io_o) && $stable(aux_io_oe_o))
		else $error("aux pins changed while deselected");
	chk_single_stops: assert property ($fell(busy_o) && single_shot_mode_o |-> !conv_start_o [*8])
		else $error("single conversion restarted");
endmodule

bind acs_ctrl acs_ctrl_assertions u_chk (
	.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i),
	.rdy_dout_o(rdy_dout_o), .rdy_dout_oe_o(rdy_dout_oe_o), .aux_io_o(aux_io_o),
	.aux_io_oe_o(aux_io_oe_o), .sample_tick_o(sample_tick_o), .conv_start_o(conv_start_o),
	.mains_freq_select_o(mains_freq_select_o), .ext_clock_select_o(ext_clock_select_o),
	.single_shot_mode_o(single_shot_mode_o), .active_rate_o(active_rate_o), .busy_o(busy_o));

//--- tb/acs_host.sv
module acs_host (
	// Clock
	input logic mclk_i,
	// Serial pins, host side
	output logic sclk_o,
	output logic cs_b_o,
	output logic din_o,
	input logic dout_i,
	input logic oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		din_o = 1'b0;
	end
	// Clock idles low between frames; a larger hp stalls the host
	task automatic xfer(input logic [31:0] bits, input int n, input int hp, output logic [23:0] rd);
		rd = 24'h000000;
		@(posedge mclk_i);
		cs_b_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk_i);
			din_o <= bits[31 - i];
			repeat (hp) @(posedge mclk_i);
			sclk_o <= 1'b1;
			rd = {rd[22:0], dout_i};
			repeat (hp) @(posedge mclk_i);
			sclk_o <= 1'b0;
			repeat (hp - 1) @(posedge mclk_i);
		end
		@(posedge mclk_i);
		cs_b_o <= 1'b1;
		din_o <= ~din_o;
	endtask
	task automatic wait_ready(output logic got);
		got = 1'b0;
		@(posedge mclk_i);
		cs_b_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
		for (int i = 0; i < 40000 && !got; i++) begin
			@(posedge mclk_i);
			got = oe_i === 1'b1 && dout_i === 1'b0;
		end
		@(posedge mclk_i);
		cs_b_o <= 1'b1;
	endtask
endmodule

//--- tb/adc_clock_rate_serial_ctrl_test.sv
module adc_clock_rate_serial_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic sclk_i, cs_b_i, din_i, rdy_dout_o, rdy_dout_oe_o, got;
	logic [3:0] aux_io_o, aux_io_oe_o;
	logic [3:0] aux_ext = 4'h3;
	logic [23:0] filter_data = 24'h000000;
	logic [23:0] rd;
	logic sample_tick_o, conv_start_o, buf_o, unip_o, mains_o, ext_o, single_o, busy_o;
	logic [2:0] rate_o;
	int fail_count = 0;
	int num_checks = 0;
	int starts = 0;
	int ticks = 0;
	int t_start = 0;
	int ext_cnt = 0;
	logic ext_clk = 1'b0;
	always #4 mclk_i = ~mclk_i;
	// Period of 56 mclk, close to the clock that rejects both mains frequencies
	always @(posedge mclk_i) begin
		ext_cnt <= (ext_cnt == 27) ? 0 : ext_cnt + 1;
		if (ext_cnt == 27)
			ext_clk <= ~ext_clk;
	end
	always @(posedge mclk_i) begin
		starts <= starts + int'(conv_start_o === 1'b1);
		ticks <= ticks + int'(sample_tick_o === 1'b1);
		if (conv_start_o === 1'b1)
			t_start <= ticks;
	end
	// Shift 13 keeps the slowest code near thirty ticks
	acs_ctrl #(.CONV_DIV_SHIFT(13)) DUT (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .sclk_i(sclk_i), .cs_b_i(cs_b_i),
		.din_i(din_i), .rdy_dout_o(rdy_dout_o), .rdy_dout_oe_o(rdy_dout_oe_o), .ext_clk_i(ext_clk),
		.aux_io_i((aux_io_oe_o & aux_io_o) | (~aux_io_oe_o & aux_ext)), .aux_io_o(aux_io_o),
		.aux_io_oe_o(aux_io_oe_o), .filter_data_i(filter_data), .sample_tick_o(sample_tick_o),
		.conv_start_o(conv_start_o), .input_buffer_enable_o(buf_o), .unipolar_o(unip_o),
		.mains_freq_select_o(mains_o), .ext_clock_select_o(ext_o),
		.single_shot_mode_o(single_o), .active_rate_o(rate_o), .busy_o(busy_o));
	acs_host host (.mclk_i(mclk_i), .sclk_o(sclk_i), .cs_b_o(cs_b_i), .din_o(din_i),
		.dout_i(rdy_dout_oe_o ? rdy_dout_o : 1'bz), .oe_i(rdy_dout_oe_o));
	task check(input logic [23:0] seen, input logic [23:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
		end
	endtask
	task conclude;
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [2:0] adr, input logic [7:0] val);
		logic [23:0] unused;
		host.xfer({1'b0, adr, 4'h0, val, 16'h0000}, 16, 2, unused);
	endtask
	task automatic rdr(input logic [2:0] adr, input int hp, output logic [23:0] val);
		host.xfer({1'b1, adr, 28'h0000000}, 32, hp, val);
	endtask
	task automatic wait_start(input int s0);
		for (int i = 0; i < 300 && starts == s0; i++)
			@(negedge mclk_i);
		check(24'(starts - s0), 24'h000001);
	endtask
	task automatic t_reset;
		check({rdy_dout_o, rdy_dout_oe_o, aux_io_oe_o, aux_io_o, mains_o, single_o}, 24'h000800);
		rdr(3'h1, 2, rd);
		check(rd[23:16], 8'h00);
		rdr(3'h3, 2, rd);
		check(rd[23:16], 8'h00);
	endtask
	task automatic t_single;
		int s0;
		filter_data <= 24'h800123;
		wr(3'h1, 8'h0F);
		check({buf_o, unip_o, mains_o, single_o}, 24'h000000);
		rdr(3'h1, 2, rd);
		check(rd[23:16], 8'h0F);
		s0 = starts;
		wr(3'h3, 8'h07);
		wait_start(s0);
		check({buf_o, unip_o, mains_o, ext_o, single_o, rate_o}, 24'h0000EF);
		host.wait_ready(got);
		check(got, 24'h000001);
		rdr(3'h0, 2, rd);
		check(rd, 24'h000000);
	endtask
	task automatic t_sweep;
		int nexp [8] = '{30, 12, 6, 3, 2, 1, 1, 1};
		int s0;
		wr(3'h1, 8'h01);
		for (int c = 0; c < 8; c++) begin
			filter_data <= 24'hA5C3E0 + 24'(c);
			s0 = starts;
			wr(3'h3, {5'h00, c[2:0]});
			wait_start(s0);
			check(rate_o, 24'(c));
			host.wait_ready(got);
			check(24'(ticks - t_start), 24'(nexp[c]));
			rdr(3'h0, 2, rd);
			check(rd, 24'hA5C3E0 + 24'(c));
		end
	endtask
	task automatic t_aux;
		wr(3'h2, 8'hA5);
		check({aux_io_oe_o, aux_io_o}, 24'h0000A5);
		rdr(3'h2, 2, rd);
		check(rd[23:16], 8'hA1);
		host.xfer({8'h20, 8'h3C, 16'h0000}, 12, 2, rd);
		check({aux_io_oe_o, aux_io_o}, 24'h0000A5);
	endtask
	task automatic t_ext;
		int s0;
		time t0;
		wr(3'h1, 8'h11);
		s0 = starts;
		wr(3'h3, 8'h04);
		wait_start(s0);
		check(ext_o, 24'h000001);
		@(posedge sample_tick_o);
		t0 = $time;
		@(posedge sample_tick_o);
		check(24'(($time - t0) / 8), 24'h000230);
		host.wait_ready(got);
		check(got, 24'h000001);
		rdr(3'h0, 2, rd);
		check(rd, 24'hA5C3E7);
	endtask
	task automatic t_fill;
		int s0;
		filter_data <= 24'h3C5A69;
		wr(3'h1, 8'h00);
		s0 = starts;
		wr(3'h3, 8'h07);
		host.wait_ready(got);
		check(24'(int'(starts - s0 == 4 || starts - s0 == 5)), 24'h000001);
		rd = 24'h000000;
		for (int i = 0; i < 80 && rd[23:21] !== 3'b101; i++) begin
			repeat (300) @(posedge mclk_i);
			rdr(3'h3, 2, rd);
		end
		check(rd[23:16], 8'hA7);
		wr(3'h3, 8'h87);
		for (int i = 0; i < 16; i++) begin
			rdr(3'h0, 6, rd);
			check(rd, 24'h3C5A69);
		end
		rdr(3'h0, 2, rd);
		check(rd, 24'h000000);
		rdr(3'h3, 2, rd);
		check(rd[23:16], 8'h07);
	endtask
	initial begin
		#780000;
		fail_count++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		t_reset;
		t_single;
		t_sweep;
		t_aux;
		t_ext;
		t_fill;
		conclude;
	end
endmodule
